// ===== verilog/port_one.sv
// Purpose: three-pin general I/O port with per-pin function selection
// Assumes: AHB-Lite slave on MCLK, pins synchronised before use
// Notes: peripheral control fields arrive as same-clock inputs
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module port_one (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // port pins
    input wire logic [port_one_pkg::PIN_CNT-1:0] PIN_IN,
    output logic [port_one_pkg::PIN_CNT-1:0] PIN_OUT,
    output logic [port_one_pkg::PIN_CNT-1:0] PIN_OE_N,
    output logic [port_one_pkg::PIN_CNT-1:0] PULLUP_ON,
    // peripheral control fields
    input wire logic EVENT_COUNTER_PWM_ENABLE,
    input wire logic [1:0] INT_ONE_PIN_SELECT,
    input wire logic [2:0] TIMER_IO_CONTROL,
    // peripheral outputs to pins
    input wire logic EVENT_COUNTER_PWM_OUT,
    input wire logic TIMER_A_IO_OUT,
    input wire logic WATCH_TIMER_OUT,
    // pin levels to peripherals
    output logic EVENT_COUNTER_IRQ_IN,
    output logic EVENT_LOW_IN,
    output logic EVENT_HIGH_IN,
    output logic TIMER_EXT_CLOCK_IN,
    output logic TIMER_A_IO_IN,
    output logic EXTERNAL_INTERRUPT_ONE,
    // power state
    input wire logic OSC_STOPPED,
    input wire logic STANDBY
);
    import port_one_pkg::*;

    // overview: the bus side keeps four small registers, the pin side
    // turns them into drive, enable and pull-up levels one cycle later,
    // and the input side hands synchronised pad levels to whichever
    // peripheral owns each pin. every top output is a flop, so a pad
    // never glitches while the function decode settles.
    // the peripheral control fields come from logic on this clock and
    // are used as they stand; the pads go through two flops first.
    // no power input touches the registers, only the clock-output pin.

    // decode a register hit from a latched write offset or the live read offset
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    // only the implemented bits are stored; reserved bits have no flops,
    // so a write there is dropped and a read returns zero
    // ---- register state ----
    logic [PIN_CNT-1:0] data_r; // output data latch
    logic [PIN_CNT-1:0] dir_r; // direction, 1 output
    logic [PIN_CNT-1:0] pull_r; // pull-up control
    logic [FUNC_W-1:0] func_r; // function select
    logic [PIN_CNT-1:0] data_nxt;
    logic [PIN_CNT-1:0] dir_nxt;
    logic [PIN_CNT-1:0] pull_nxt;
    logic [FUNC_W-1:0] func_nxt;

    // the slave never stalls: a write is taken in its address phase and
    // lands at the end of the data phase, a read answers from a register
    // loaded at the address phase, so hreadyout can be a constant one
    // ---- bus state ----
    logic wr_pend_r; // write data phase pending
    logic [7:0] wr_addr_r; // latched write offset
    logic wr_lane_r; // lane zero covered
    logic [31:0] rdata_r; // read data register
    logic [31:0] rdata_nxt;
    logic ready_r; // always ready
    logic resp_r; // always okay

    // pads are asynchronous to the system clock; nothing but the second
    // stage may be read, or a metastable first stage could leak into
    // both the read data and a peripheral input in the same cycle
    // ---- pin sync ----
    logic [PIN_CNT-1:0] sync_a_r; // first stage
    logic [PIN_CNT-1:0] pin_r; // second stage, safe to read

    // drive and value are registered together so the enable and the
    // level change on the same edge and the pad sees no runt pulse
    // ---- pin drive ----
    logic [PIN_CNT-1:0] out_r;
    logic [PIN_CNT-1:0] oe_n_r;
    logic [PIN_CNT-1:0] pull_on_r;
    logic [PIN_CNT-1:0] out_nxt;
    logic [PIN_CNT-1:0] drive_nxt; // 1 when driving
    logic [PIN_CNT-1:0] gpio_sel; // pin in general mode

    // each routed level is forced to zero while its function is not
    // selected, so only timer A in timer-input shared mode sees a general-purpose pad toggle
    // ---- peripheral input flops ----
    logic evt_irq_r;
    logic evt_low_r;
    logic evt_high_r;
    logic tmr_clk_r;
    logic tmr_a_r;
    logic external_interrupt_one_r;

    // an access is only taken with hready high; a master stalled by
    // another slave must not let a stale address phase in twice
    // ---- address phase ----
    wire addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    wire wr_take = addr_ok && HWRITE;
    wire rd_take = addr_ok && !HWRITE;
    wire [7:0] off_a = HADDR[7:0];
    // word access or any smaller access touching byte zero
    wire lane0 = (HSIZE == HSIZE_WORD) || (HADDR[1:0] == 2'h0);
    wire hi_zero = (HADDR[31:8] == 24'h0);

    // the write target is decided from the address phase registers;
    // the data phase only supplies hwdata, which is valid one cycle later
    // ---- write decode in data phase ----
    wire wr_go = wr_pend_r && wr_lane_r;
    wire wr_data = wr_go && reg_hit(wr_addr_r, OFF_DATA);
    wire wr_dir = wr_go && reg_hit(wr_addr_r, OFF_DIR);
    wire wr_pull = wr_go && reg_hit(wr_addr_r, OFF_PULLUP);
    wire wr_func = wr_go && reg_hit(wr_addr_r, OFF_FUNC);

    // only the implemented low bits are taken
    assign data_nxt = wr_data ? HWDATA[PIN_CNT-1:0] : data_r;
    assign dir_nxt = wr_dir ? HWDATA[PIN_CNT-1:0] : dir_r;
    assign pull_nxt = wr_pull ? HWDATA[PIN_CNT-1:0] : pull_r;
    assign func_nxt = wr_func ? HWDATA[FUNC_W-1:0] : func_r;

    // the read value is captured at the address phase edge, so the
    // synchronised pad state seen is two to three cycles behind the pad
    // ---- read path ----
    // per-bit mix of latch and live pin
    wire [PIN_CNT-1:0] data_view = (dir_r & data_r) | (~dir_r & pin_r);
    wire rd_data = hi_zero && reg_hit(off_a, OFF_DATA);
    wire rd_pull = hi_zero && reg_hit(off_a, OFF_PULLUP);
    wire rd_func = hi_zero && reg_hit(off_a, OFF_FUNC);
    // direction reads give zero, unmapped reads give zero
    assign rdata_nxt = !rd_take ? rdata_r :
                       rd_data ? {29'h0, data_view} :
                       rd_pull ? {29'h0, pull_r} :
                       rd_func ? {26'h0, func_r} : WORD_ZERO;

    // wr_addr_r and wr_lane_r load every cycle; they are only used when
    // wr_pend_r says the previous cycle held a write address phase
    // bus flops
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_lane_r <= 1'b0;
            rdata_r <= WORD_ZERO;
            ready_r <= 1'b1;
            resp_r <= HRESP_OKAY;
        end else begin
            wr_pend_r <= wr_take && hi_zero;
            wr_addr_r <= off_a;
            wr_lane_r <= lane0;
            rdata_r <= rdata_nxt;
            ready_r <= 1'b1;
            resp_r <= HRESP_OKAY;
        end
    end

    // software sees a written value on the pins one edge after this
    // update, because the pin drive flops sample the new register
    // register flops, all cleared at reset
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            data_r <= PIN_RST;
            dir_r <= PIN_RST;
            pull_r <= PIN_RST;
            func_r <= FUNC_RST;
        end else begin
            data_r <= data_nxt;
            dir_r <= dir_nxt;
            pull_r <= pull_nxt;
            func_r <= func_nxt;
        end
    end

    // reset clears both stages; the first reads after release may show
    // zero for a pad that is already high
    // two-stage pin synchroniser, one per pin
    genvar g;
    generate
        for (g = 0; g < PIN_CNT; g++) begin : g_sync
            always_ff @(posedge MCLK) begin
                if (!RESETN) begin
                    sync_a_r[g] <= 1'b0;
                    pin_r[g] <= 1'b0;
                end else begin
                    sync_a_r[g] <= PIN_IN[g];
                    pin_r[g] <= sync_a_r[g];
                end
            end
        end
    endgenerate

    // pin two belongs to the event counter whenever its mode bit is set;
    // the counter's pwm enable alone decides output versus interrupt input
    // ---- pin two function ----
    wire p2_alt = func_r[F_PIN2_ALT];
    wire p2_pwm = p2_alt && EVENT_COUNTER_PWM_ENABLE;
    wire p2_irq = p2_alt && !EVENT_COUNTER_PWM_ENABLE;

    // the interrupt-1 select lives in another block and wins over the
    // mode bits here; the timer clock wins over the event-low input
    // ---- pin one function ----
    wire p1_int = (INT_ONE_PIN_SELECT == EXTERNAL_INTERRUPT_ONE_ON_PIN1);
    wire p1_tclk = !p1_int && func_r[F_PIN1_TCLK];
    wire p1_evl = !p1_int && !func_r[F_PIN1_TCLK] && func_r[F_PIN1_EVL];

    // pin zero has the richest decode: three mode bits pick a function,
    // and in shared mode the timer's own control can still take the pin
    // ---- pin zero function ----
    pin0_func_t p0_mode;
    assign p0_mode = pin0_func_t'(func_r[F_PIN0_HI:F_PIN0_LO]);
    wire p0_shared = (p0_mode == P0_SHARED);
    wire p0_evh = (p0_mode == P0_EVT_HIGH);
    wire p0_watch = (p0_mode == P0_WATCH_A) || (p0_mode == P0_WATCH_B);
    // prohibited code counts as no clock output
    wire p0_clk = func_r[F_PIN0_HI] && (p0_mode != P0_PROHIB);
    // timer A control inside shared mode
    wire tio_out = p0_shared && !TIMER_IO_CONTROL[2]
                   && (TIMER_IO_CONTROL[1:0] != 2'h0);
    wire tio_in = p0_shared && TIMER_IO_CONTROL[2];

    // in timer-input shared mode the pin stays general, so direction and
    // data still act while the timer also watches the pad
    // general mode per pin, others ignore data and direction
    assign gpio_sel[2] = !p2_alt;
    assign gpio_sel[1] = !p1_int && !p1_tclk && !p1_evl;
    assign gpio_sel[0] = p0_shared && !tio_out;

    // the divider is stopped and cleared whenever clock output is not
    // selected; changing the ratio while it runs could emit a short pulse
    // ---- clock-output divider ----
    clk_out_if co ();
    assign co.run = p0_clk;
    // ratio is only meant to change while stopped
    assign co.ratio = func_r[1:0];
    assign co.freeze = OSC_STOPPED;

    clk_out_divider u_div (
        .MCLK(MCLK),
        .RESETN(RESETN),
        .co(co)
    );

    // standby floats the clock-output pin but a plain oscillator stop
    // keeps driving the frozen level; other pins ignore both power inputs,
    // since their drive does not depend on the oscillator
    // per-pin drive selection
    assign drive_nxt[2] = p2_pwm || (gpio_sel[2] && dir_r[2]);
    assign drive_nxt[1] = gpio_sel[1] && dir_r[1];
    assign drive_nxt[0] = (p0_clk && !STANDBY) || p0_watch || tio_out
                          || (gpio_sel[0] && dir_r[0]);
    assign out_nxt[2] = p2_pwm ? EVENT_COUNTER_PWM_OUT : data_r[2];
    assign out_nxt[1] = data_r[1];
    assign out_nxt[0] = p0_clk ? co.level :
                        p0_watch ? WATCH_TIMER_OUT :
                        tio_out ? TIMER_A_IO_OUT : data_r[0];

    // a peripheral input other than shared-mode timer A keeps its pull-up off so the external source
    // alone sets the level the peripheral sees
    // pull-up only on general-mode inputs
    wire [PIN_CNT-1:0] pull_nxt_on = pull_r & ~dir_r & gpio_sel;

    // an undriven pad rests its output value low, so the data latch of a
    // pin given to a peripheral never shows on the pad side
    // pin drive flops
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            out_r <= PIN_RST;
            oe_n_r <= ~PIN_RST;
            pull_on_r <= PIN_RST;
        end else begin
            out_r <= out_nxt & drive_nxt;
            oe_n_r <= ~drive_nxt;
            pull_on_r <= pull_nxt_on;
        end
    end

    // these add one edge after the synchroniser, so a pad change reaches
    // a peripheral on the third edge
    // pin levels handed to peripherals, zero when not routed
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            evt_irq_r <= 1'b0;
            evt_low_r <= 1'b0;
            evt_high_r <= 1'b0;
            tmr_clk_r <= 1'b0;
            tmr_a_r <= 1'b0;
            external_interrupt_one_r <= 1'b0;
        end else begin
            evt_irq_r <= p2_irq && pin_r[2];
            evt_low_r <= p1_evl && pin_r[1];
            tmr_clk_r <= p1_tclk && pin_r[1];
            external_interrupt_one_r <= p1_int && pin_r[1];
            evt_high_r <= p0_evh && pin_r[0];
            tmr_a_r <= tio_in && pin_r[0];
        end
    end

    // plain wiring from flops to ports; no logic sits between them
    // output hookup
    assign HRDATA = rdata_r;
    assign HREADYOUT = ready_r;
    assign HRESP = resp_r;
    assign PIN_OUT = out_r;
    assign PIN_OE_N = oe_n_r;
    assign PULLUP_ON = pull_on_r;
    assign EVENT_COUNTER_IRQ_IN = evt_irq_r;
    assign EVENT_LOW_IN = evt_low_r;
    assign EVENT_HIGH_IN = evt_high_r;
    assign TIMER_EXT_CLOCK_IN = tmr_clk_r;
    assign TIMER_A_IO_IN = tmr_a_r;
    assign EXTERNAL_INTERRUPT_ONE = external_interrupt_one_r;
endmodule // port_one

// ===== pkg/port_one_pkg.sv
// Purpose: shared constants and types for the three-pin port block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses on the bus
package port_one_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_DIR = 8'h04;
    localparam logic [7:0] OFF_PULLUP = 8'h08;
    localparam logic [7:0] OFF_FUNC = 8'h0C;
    // port width and function select layout
    localparam int PIN_CNT = 3;
    localparam int FUNC_W = 6;
    localparam int F_PIN2_ALT = 5;
    localparam int F_PIN1_TCLK = 4;
    localparam int F_PIN1_EVL = 3;
    localparam int F_PIN0_HI = 2;
    localparam int F_PIN0_LO = 0;
    // values after reset
    localparam logic [2:0] PIN_RST = 3'h0;
    localparam logic [5:0] FUNC_RST = 6'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // interrupt-1 pin select value that claims pin one
    localparam logic [1:0] EXTERNAL_INTERRUPT_ONE_ON_PIN1 = 2'h2;
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;
    // divider counter width and reset
    localparam int DIV_W = 3;
    localparam logic [2:0] DIV_RST = 3'h0;
    // pin zero function codes
    typedef enum logic [2:0] {
        P0_SHARED = 3'b000,
        P0_EVT_HIGH = 3'b001,
        P0_WATCH_A = 3'b010,
        P0_WATCH_B = 3'b011,
        P0_CLK_DIV1 = 3'b100,
        P0_CLK_DIV2 = 3'b101,
        P0_CLK_DIV4 = 3'b110,
        P0_PROHIB = 3'b111
    } pin0_func_t;
endpackage

// ===== pkg/clk_out_if.sv
// Purpose: carrier between the port top and its clock-output divider
// Assumes: both ends on the system clock
// Notes: ratio is the low two function bits of pin zero
`timescale 1ns/1ps
interface clk_out_if;
    logic run; // clock output selected
    logic [1:0] ratio; // 00 div1, 01 div2, 10 div4
    logic freeze; // oscillator stopped, hold level
    logic level; // divided clock level
    modport port (output run, output ratio, output freeze, input level);
    modport divider (input run, input ratio, input freeze, output level);
endinterface

// ===== verilog/clk_out_divider.sv
// Purpose: divided oscillator clock for the clock-output pin
// Assumes: oscillator clock stands for a toggle at half the system clock
// Notes: counter clears while stopped so the output rests low, unless frozen, which holds the level
`timescale 1ns/1ps
module clk_out_divider (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // link to port top
    clk_out_if.divider co
);
    import port_one_pkg::*;

    logic [DIV_W-1:0] cnt_r; // free divide counter
    logic [DIV_W-1:0] cnt_nxt;
    logic level_r; // registered output level
    logic level_nxt;

    // stop clears, freeze holds, else count
    assign cnt_nxt = !co.run ? DIV_RST :
                     co.freeze ? cnt_r : DIV_W'(cnt_r + 1'b1);
    // pick tap by ratio, hold while frozen
    assign level_nxt = co.freeze ? level_r :
                       !co.run ? 1'b0 : cnt_nxt[co.ratio];

    // counter and level flops
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            cnt_r <= DIV_RST;
            level_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign co.level = level_r;
endmodule // clk_out_divider

// ===== bench/port_one_assertions.sv
// Purpose: concurrent checks on the port top pins and bus
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every port_one instance, sees top ports only
`timescale 1ns/1ps
module port_one_assertions (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // bus side
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // pins and interrupt-1 routing
    input wire logic [2:0] PIN_IN,
    input wire logic [2:0] PIN_OE_N,
    input wire logic [2:0] PIN_OUT,
    input wire logic [2:0] PULLUP_ON,
    input wire logic [1:0] INT_ONE_PIN_SELECT,
    input wire logic EXTERNAL_INTERRUPT_ONE
);
    import port_one_pkg::*;
    // read address phase taken
    wire rd_req = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    chk_bus_okay: assert property (HREADYOUT && HRESP == HRESP_OKAY)
        else $error("bus slave stalled or errored");
    chk_reset_idle: assert property ($rose(RESETN) |->
        PIN_OE_N == 3'h7 && PIN_OUT == 3'h0 && PULLUP_ON == 3'h0)
        else $error("pins not idle after reset");
    chk_pull_in_only: assert property ((PULLUP_ON & ~PIN_OE_N) == 3'h0)
        else $error("pull-up on a driven pin");
    chk_dir_reads_zero: assert property (rd_req && HADDR == {24'h0, OFF_DIR}
        |=> HRDATA == WORD_ZERO)
        else $error("direction read not zero");
    chk_upper_bits_zero: assert property (rd_req |=> HRDATA[31:FUNC_W] == '0)
        else $error("reserved read bits set");
    chk_external_interrupt_one_undriven: assert property ((INT_ONE_PIN_SELECT == EXTERNAL_INTERRUPT_ONE_ON_PIN1) [*2]
        |-> PIN_OE_N[1] && !PULLUP_ON[1])
        else $error("pin one driven while interrupt input");
    chk_external_interrupt_one_follows: assert property ((INT_ONE_PIN_SELECT == EXTERNAL_INTERRUPT_ONE_ON_PIN1) [*4]
        |-> EXTERNAL_INTERRUPT_ONE == $past(PIN_IN[1], 3))
        else $error("interrupt one not following pin");
    chk_external_interrupt_one_quiet: assert property ((INT_ONE_PIN_SELECT != EXTERNAL_INTERRUPT_ONE_ON_PIN1) [*2]
        |-> !EXTERNAL_INTERRUPT_ONE)
        else $error("interrupt one active while unselected");
endmodule // port_one_assertions
bind port_one port_one_assertions i_chk (.MCLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .PIN_IN, .PIN_OE_N, .PIN_OUT, .PULLUP_ON,
    .INT_ONE_PIN_SELECT, .EXTERNAL_INTERRUPT_ONE);

// ===== bench/port_one_board.sv
// Purpose: board-side pads around the port
// Assumes: external source and pull-up resolve each pad
// Notes: an undriven pad without pull-up wanders every cycle
`timescale 1ns/1ps
module port_one_board (
    // clock
    input wire logic mclk,
    // pad controls from the port
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [2:0] pullup_on,
    // external source
    input wire logic [2:0] ext_val,
    input wire logic [2:0] ext_en,
    // resolved pad level
    output logic [2:0] pin_in
);
    logic [2:0] float_r = 3'h5; // wandering level
    // floating pads flip each cycle
    always @(posedge mclk) begin
        float_r <= ~float_r;
    end
    // port drive wins, then source, then pull-up
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pullup_on[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_r[i];
        end
    end
endmodule // port_one_board

// ===== bench/port_one_bench.sv
// Purpose: self-checking bench for the three-pin port
// Assumes: single-word AHB-Lite master, zero-wait slave
// Notes: pin levels settle a few cycles after each write
`timescale 1ns/1ps
module port_one_bench;
    import port_one_pkg::*;
    // clock, reset and bus
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] haddr = WORD_ZERO, hwdata = WORD_ZERO, hrdata;
    logic hreadyout, hresp;
    wire logic hready = hreadyout !== 1'b0;
    // peripheral side and board source
    logic pwm_en = 1'b0, pwm_out = 1'b1, ta_out = 1'b0, wt_out = 1'b0;
    logic osc_stop = 1'b0, standby = 1'b0;
    logic [1:0] irq_sel = 2'h0;
    logic [2:0] tio = 3'h0, ext_val = 3'h5, ext_en = 3'h7;
    logic [2:0] pin_in, pin_out, pin_oe_n, pullup_on;
    logic irq_in, evl_in, evh_in, tclk_in, ta_in, int1, prev;
    int n_fail = 0, compares = 0, cyc_cnt = 0, n;
    port_one i_dut (.MCLK(mclk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PULLUP_ON(pullup_on),
        .EVENT_COUNTER_PWM_ENABLE(pwm_en), .INT_ONE_PIN_SELECT(irq_sel),
        .TIMER_IO_CONTROL(tio), .EVENT_COUNTER_PWM_OUT(pwm_out), .TIMER_A_IO_OUT(ta_out),
        .WATCH_TIMER_OUT(wt_out), .EVENT_COUNTER_IRQ_IN(irq_in), .EVENT_LOW_IN(evl_in),
        .EVENT_HIGH_IN(evh_in), .TIMER_EXT_CLOCK_IN(tclk_in), .TIMER_A_IO_IN(ta_in),
        .EXTERNAL_INTERRUPT_ONE(int1), .OSC_STOPPED(osc_stop), .STANDBY(standby));
    port_one_board i_board (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    // 20 MHz clock
    initial forever #25 mclk = ~mclk;
    // verdict and stop
    task automatic end_sim;
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // compare and report
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, WORD_ZERO, q);
        chk(nm, q, e);
    endtask
    // wait edges, then step off the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            n_fail++;
            end_sim;
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        cyc(3);
        rd("data_in", OFF_DATA, 32'h5);
        rd("dir_rd", OFF_DIR, 32'h0);
        rd("pull_rst", OFF_PULLUP, 32'h0);
        rd("func_rst", OFF_FUNC, 32'h0);
        rd("unmapped", 8'h10, 32'h0);
        wr(OFF_DIR, 32'hFF);
        wr(OFF_DATA, 32'hFA);
        wr(OFF_PULLUP, 32'hFF);
        cyc(2);
        chk("oe_out", {pin_oe_n, pin_out, pullup_on}, 9'h010);
        rd("data_latch", OFF_DATA, 32'h2);
        rd("pull_rd", OFF_PULLUP, 32'h7);
        wr(OFF_DIR, 32'h0);
        @(posedge mclk) ext_en <= 3'h0;
        cyc(4);
        chk("pull_in", pullup_on, 3'h7);
        rd("pulled", OFF_DATA, 32'h7);
        wr(OFF_PULLUP, 32'h5);
        @(posedge mclk) ext_en <= 3'h7;
        cyc(2);
        chk("pull_sel", pullup_on, 3'h5);
        wr(OFF_FUNC, 32'hF8);
        rd("func_rd", OFF_FUNC, 32'h38);
        wr(OFF_DIR, 32'h7);
        wr(OFF_DATA, 32'h1);
        for (int c = 0; c < 7; c++) begin
            wr(OFF_FUNC, 32'h0);
            wr(OFF_FUNC, c);
            cyc(2);
            chk("p0_oe", {pin_oe_n[0], evh_in}, {2{c == 1}});
            if (c < 4) chk("p0_out", pin_out[0], c == 0);
            else begin
                n = 0;
                repeat (32) begin
                    prev = pin_out[0];
                    cyc(1);
                    n += (!prev && pin_out[0]);
                end
                chk("p0_rate", n, 16 >> (c - 4));
            end
        end
        @(posedge mclk) osc_stop <= 1'b1;
        cyc(2);
        prev = pin_out[0];
        cyc(4);
        chk("clk_hold", pin_out[0], prev);
        @(posedge mclk) standby <= 1'b1;
        cyc(2);
        chk("clk_float", pin_oe_n[0], 1'b1);
        wr(OFF_FUNC, 32'h0);
        @(posedge mclk) standby <= 1'b0;
        @(posedge mclk) osc_stop <= 1'b0;
        for (int t = 1; t < 3; t++) begin
            @(posedge mclk) tio <= 3'(t);
            cyc(2);
            chk("ta_out", {pin_oe_n[0], pin_out[0]}, 2'h0);
        end
        @(posedge mclk) tio <= 3'h4;
        cyc(6);
        chk("ta_in", {pin_oe_n[0], pin_out[0], ta_in}, 3'h3);
        @(posedge mclk) pwm_en <= 1'b1;
        wr(OFF_FUNC, 32'h20);
        cyc(2);
        chk("pwm", {pin_oe_n[2], pin_out[2]}, 2'h1);
        @(posedge mclk) pwm_en <= 1'b0;
        cyc(6);
        chk("event_counter_irq_select", {pin_oe_n[2], irq_in}, 2'h3);
        @(posedge mclk) ext_val <= 3'h7;
        wr(OFF_FUNC, 32'h08);
        cyc(6);
        chk("evl", {pin_oe_n[1], evl_in, tclk_in}, 3'h6);
        wr(OFF_FUNC, 32'h18);
        cyc(2);
        chk("tclk", {pin_oe_n[1], evl_in, tclk_in}, 3'h5);
        wr(OFF_FUNC, 32'h0);
        @(posedge mclk) irq_sel <= EXTERNAL_INTERRUPT_ONE_ON_PIN1;
        cyc(6);
        chk("external_interrupt_one", {pin_oe_n[1], int1}, 2'h3);
        end_sim;
    end
endmodule // port_one_bench
